// ### bench/tb_watchdog_timeout_control.sv
// Purpose: bench for the watchdog
// Assumes: LF_DIV of 4
// Notes: periods allow a few cycles of pipeline
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"
module tb_watchdog_timeout_control;
    localparam int DIV = 4;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleep_mode = 0;
    logic clear_watchdog_instr = 0, osc_fail = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [7:0] cfg_word = 0;
    logic hreadyout, hresp, wdt_reset_req, wake_req, timeout_flag, powerdown_flag;
    logic watchdog_active;
    int failures = 0, checks = 0, fires = 0, n, t, f;
    int sels[4] = '{0, 2, 19, 31};
    watchdog_timeout_control #(.LF_DIV(DIV)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .cfg_word, .sleep_mode, .clear_watchdog_instr, .osc_fail, .wdt_reset_req, .wake_req,
        .timeout_flag, .powerdown_flag, .watchdog_active);
    initial forever #2 hclk = ~hclk;
    always @(posedge hclk) if (wdt_reset_req === 1'b1) fires++;
    // ----
    // tasks
    // ----
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (i >= 50) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic kick(input logic osc);
        clear_watchdog_instr <= !osc;
        osc_fail <= osc;
        @(posedge hclk);
        clear_watchdog_instr <= 1'b0;
        osc_fail <= 1'b0;
    endtask
    task automatic measure(input int lim, input bit must_fire);
        n = 0;
        while (wdt_reset_req !== 1'b1 && wake_req !== 1'b1 && n < lim) begin
            @(posedge hclk);
            n++;
        end
        if (must_fire && n >= lim) begin
            failures++;
            wrap_up();
        end
    endtask
    // ----
    // sequence
    // ----
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(0, `WDT_CTRL_OFF, ZERO);
        chk("ctrl reset", rd, 32'h0000_0016);
        xfer(1, `WDT_CTRL_OFF, 32'hffff_ffc1);
        xfer(0, `WDT_CTRL_OFF, ZERO);
        chk("ctrl bits", rd, 32'h0000_0001);
        xfer(1, 8'h0c, 32'hffff_ffff);
        xfer(0, 8'h0c, ZERO);
        chk("unmapped", rd, ZERO);
        $display("end registers");
        for (int k = 0; k < 8; k++) begin
            cfg_word <= {3'b000, 2'(k), 3'b000};
            sleep_mode <= k[2];
            repeat (8) @(posedge hclk);
            chk("active", watchdog_active, k % 4 == 3 || k % 4 == 1 || k == 2);
        end
        xfer(1, `WDT_CTRL_OFF, ZERO);
        cfg_word <= 8'h08;
        sleep_mode <= 1'b0;
        repeat (8) @(posedge hclk);
        chk("soft off", watchdog_active, 1'b0);
        cfg_word <= 8'h18;
        repeat (8) @(posedge hclk);
        $display("end modes");
        foreach (sels[i]) begin
            kick(1'b0);
            xfer(1, `WDT_CTRL_OFF, 32'(sels[i] << 1));
            kick(1'b0);
            measure(2000, 1'b1);
            t = ((sels[i] > 18) ? 32 : 32 << sels[i]) * DIV;
            chk("period", 32'(n > t - 6 && n < t + 6), 32'h0000_0001);
            chk("awake reset", wdt_reset_req, 1'b1);
            chk("timeout flag", timeout_flag, 1'b1);
        end
        xfer(0, `WDT_STAT_OFF, ZERO);
        chk("status", rd, 32'h0000_001d);
        xfer(1, `WDT_STAT_OFF, 32'h0000_0003);
        xfer(0, `WDT_STAT_OFF, ZERO);
        chk("status clear", rd, 32'h0000_001c);
        $display("end periods");
        kick(1'b0);
        f = fires;
        for (int k = 0; k < 4; k++) begin
            repeat (100) @(posedge hclk);
            kick(k[0]);
        end
        chk("held off", fires, f);
        $display("end clears");
        sleep_mode <= 1'b1;
        measure(2000, 1'b1);
        chk("sleep period", 32'(n > 122 && n < 136), 32'h0000_0001);
        chk("wake", wake_req, 1'b1);
        @(posedge hclk);
        chk("pd flag", powerdown_flag, 1'b1);
        chk("no reset", fires, f);
        cfg_word <= 8'h10;
        repeat (8) @(posedge hclk);
        measure(600, 1'b0);
        chk("off asleep", n, 600);
        $display("end sleep");
        wrap_up();
    end
endmodule
`default_nettype wire

// ### bench/watchdog_timeout_control_chk.sv
// Purpose: port checks for the watchdog
// Assumes: hready tied to hreadyout
// Notes: mode settles within seven cycles
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_control_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:0] cfg_word,
    input wire logic wdt_reset_req,
    input wire logic wake_req,
    input wire logic timeout_flag,
    input wire logic powerdown_flag,
    input wire logic watchdog_active
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    write_fast_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write stalled");
    resp_okay_a: assert property (!hresp) else $error("error response");
    reset_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("reset pulse too long");
    wake_pulse_a: assert property (wake_req |=> !wake_req)
        else $error("wake pulse too long");
    awake_fire_a: assert property (wdt_reset_req |-> timeout_flag && !wake_req)
        else $error("awake timeout wrong");
    sleep_fire_a: assert property (wake_req |-> timeout_flag && powerdown_flag)
        else $error("sleep timeout flags wrong");
    mode_off_a: assert property ((cfg_word[4:3] == 2'b00) [*7]
        |-> !watchdog_active && !wdt_reset_req) else $error("active in mode off");
    mode_on_a: assert property ((cfg_word[4:3] == 2'b11) [*7] |-> watchdog_active)
        else $error("idle in mode always");
endmodule
bind watchdog_timeout_control watchdog_timeout_control_chk u_chk (.hclk, .hresetn, .hsel,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .cfg_word, .wdt_reset_req, .wake_req,
    .timeout_flag, .powerdown_flag, .watchdog_active);
`default_nettype wire

// ### pkg/wdt_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the watchdog
// Assumes: 32-bit bus words, one register per aligned word
// Notes: the contract list of the block follows
//
// Contract
// - timeout code zero is 1:32, doubling upward
// - reset loads timeout code 01011 (2 s)
// - control bit 0 enables when mode delegates
// - control bits 7 and 6 read zero
// - mode taken from config byte bits 4:3
// - mode 11 always, 10 awake, 01 software
// - codes 10011 and above select 1:32
// - count cleared on reset, clear, sleep, disable
// - timeout in sleep wakes and sets flags
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// register byte offsets
`define WDT_CTRL_OFF 8'h00
`define WDT_STAT_OFF 8'h04
`define WDT_COUNT_OFF 8'h08

// control register fields
`define WDT_CTRL_SEL_MSB 5
`define WDT_CTRL_SEL_LSB 1
`define WDT_CTRL_EN_BIT 0

// status register fields
`define WDT_STAT_TO_BIT 0
`define WDT_STAT_PD_BIT 1
`define WDT_STAT_ACT_BIT 2
`define WDT_STAT_MODE_LSB 3

// configuration byte fields
`define WDT_MODE_MSB 4
`define WDT_MODE_LSB 3

// reset values and code limits
`define WDT_SEL_RESET 5'h0b
`define WDT_SEL_FIRST_RSVD 5'h13
`define WDT_MIN_RATIO 24'h00_0020

// timing
`define WDT_HCLK_HZ 250000000
`define WDT_LF_HZ 31000
`define WDT_LF_DIV (`WDT_HCLK_HZ / `WDT_LF_HZ)

`endif

// ### pkg/wdt_pkg.sv
// Purpose: types shared by the watchdog modules
// Assumes: constants live in wdt_defs.svh
// Notes: one-hot timer states
package wdt_pkg;

    typedef enum logic [2:0] {
        WD_OFF = 3'b001,
        WD_RUN = 3'b010,
        WD_FIRE = 3'b100
    } wd_state_e;

    typedef logic [22:0] wd_count_t;

endpackage

// ### pkg/wdt_tick_if.sv
// Purpose: carries the low-frequency tick between the divider and the timer
// Assumes: single clock domain
// Notes: run gates the divider, restart realigns it
`timescale 1ns/1ps
`default_nettype none
interface wdt_tick_if;
    logic run;
    logic restart;
    logic tick;

    modport gen (
        input run,
        input restart,
        output tick
    );

    modport user (
        output run,
        output restart,
        input tick
    );
endinterface
`default_nettype wire

// ### rtl/watchdog_timeout_control.sv
// Purpose: watchdog timer with prescale select, mode decode and AHB-Lite registers
// Assumes: sleep_mode, clear_watchdog_instr and osc_fail come from logic on hclk
// Notes: cfg_word is a static level from nonvolatile storage, synchronised here
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"
module watchdog_timeout_control
    import wdt_pkg::*;
#(
    parameter int LF_DIV = `WDT_LF_DIV
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [7:0] cfg_word,
    input wire logic sleep_mode,
    input wire logic clear_watchdog_instr,
    input wire logic osc_fail,
    output logic wdt_reset_req,
    output logic wake_req,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic watchdog_active
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        wd_state_e st;
        logic [4:0] sel;
        logic soft_en;
        logic timeout_flag;
        logic pd_flag;
        wd_count_t count;
        logic [7:0] cfg_s1;
        logic [7:0] cfg_s2;
        logic [7:0] cfg_s3;
        logic [1:0] mode;
        logic sleep_d;
        logic reset_req;
        logic wake_req;
        logic active;
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_addr;
        logic ready;
        logic [31:0] rdata;
        logic resp;
    } wdt_state_s;

    wdt_state_s s;
    wdt_state_s n;

    wdt_tick_if tk ();

    logic active_d;
    logic clr;
    logic addr_take;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic wd_count_t terminal_count(input logic [4:0] sel);
        logic [23:0] ratio;
        ratio = `WDT_MIN_RATIO;
        if (sel < `WDT_SEL_FIRST_RSVD) begin
            ratio = `WDT_MIN_RATIO << sel;
        end
        // reserved codes keep the minimum ratio
        terminal_count = wd_count_t'(ratio - 24'h00_0001);
    endfunction

    function automatic logic run_enabled(input logic [1:0] mode, input logic sleeping,
                                         input logic soft_en);
        logic en;
        en = 1'b0;
        unique case (mode)
            2'b11: en = 1'b1;
            2'b10: en = !sleeping;
            2'b01: en = soft_en;
            2'b00: en = 1'b0;
        endcase
        run_enabled = en;
    endfunction

    // ------------------------------------------------------------
    // enable and clear conditions
    // ------------------------------------------------------------
    assign active_d = run_enabled(s.mode, sleep_mode, s.soft_en);

    // sleep entry, sleep exit, clear instruction, oscillator loss, disable
    assign clr = clear_watchdog_instr | (sleep_mode ^ s.sleep_d) | osc_fail | !active_d;

    assign addr_take = hsel & hready & htrans[1];

    // ------------------------------------------------------------
    // low-frequency tick
    // ------------------------------------------------------------
    assign tk.run = active_d;
    assign tk.restart = clr;

    wdt_lf_tick #(
        .DIV(LF_DIV)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tk(tk)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.reset_req = 1'b0;
        n.wake_req = 1'b0;
        n.resp = 1'b0;

        // configuration byte synchroniser
        n.cfg_s1 = cfg_word;
        n.cfg_s2 = s.cfg_s1;
        n.cfg_s3 = s.cfg_s2;
        if (s.cfg_s2[`WDT_MODE_MSB:`WDT_MODE_LSB] == s.cfg_s3[`WDT_MODE_MSB:`WDT_MODE_LSB]) begin
            n.mode = s.cfg_s3[`WDT_MODE_MSB:`WDT_MODE_LSB];
        end

        n.sleep_d = sleep_mode;
        n.active = active_d;

        // bus data phase: write
        if (s.ph_valid && s.ph_write) begin
            n.ph_valid = 1'b0;
            unique case (s.ph_addr)
                `WDT_CTRL_OFF: begin
                    n.sel = hwdata[`WDT_CTRL_SEL_MSB:`WDT_CTRL_SEL_LSB];
                    n.soft_en = hwdata[`WDT_CTRL_EN_BIT];
                    // bits 7 and 6 are not stored
                end
                `WDT_STAT_OFF: begin
                    // write one to clear
                    if (hwdata[`WDT_STAT_TO_BIT]) begin
                        n.timeout_flag = 1'b0;
                    end
                    if (hwdata[`WDT_STAT_PD_BIT]) begin
                        n.pd_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // bus data phase: read, one wait state
        if (s.ph_valid && !s.ph_write) begin
            n.ph_valid = 1'b0;
            n.ready = 1'b1;
            n.rdata = '0;
            unique case (s.ph_addr)
                `WDT_CTRL_OFF: begin
                    n.rdata[`WDT_CTRL_SEL_MSB:`WDT_CTRL_SEL_LSB] = s.sel;
                    n.rdata[`WDT_CTRL_EN_BIT] = s.soft_en;
                end
                `WDT_STAT_OFF: begin
                    n.rdata[`WDT_STAT_TO_BIT] = s.timeout_flag;
                    n.rdata[`WDT_STAT_PD_BIT] = s.pd_flag;
                    n.rdata[`WDT_STAT_ACT_BIT] = s.active;
                    n.rdata[`WDT_STAT_MODE_LSB +: 2] = s.mode;
                end
                `WDT_COUNT_OFF: begin
                    n.rdata[22:0] = s.count;
                end
                default: begin
                    n.rdata = '0;
                end
            endcase
        end

        // bus address phase
        if (addr_take) begin
            n.ph_valid = 1'b1;
            n.ph_write = hwrite;
            n.ph_addr = haddr[7:0];
            n.ready = hwrite;
        end

        // timer
        unique case (s.st)
            WD_OFF: begin
                n.count = '0;
                if (active_d) begin
                    n.st = WD_RUN;
                end
            end
            WD_RUN: begin
                if (clr) begin
                    n.count = '0;
                    if (!active_d) begin
                        n.st = WD_OFF;
                    end
                end else if (tk.tick) begin
                    if (s.count == terminal_count(s.sel)) begin
                        n.count = '0;
                        n.st = WD_FIRE;
                    end else begin
                        n.count = s.count + wd_count_t'(1);
                    end
                end
            end
            WD_FIRE: begin
                n.count = '0;
                n.st = active_d ? WD_RUN : WD_OFF;
                // set wins over a same-cycle software clear
                n.timeout_flag = 1'b1;
                if (sleep_mode) begin
                    n.wake_req = 1'b1;
                    n.pd_flag = 1'b1;
                end else begin
                    n.reset_req = 1'b1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.st <= WD_OFF;
            s.sel <= `WDT_SEL_RESET;
            s.ready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout = s.ready;
    assign hrdata = s.rdata;
    assign hresp = s.resp;
    assign wdt_reset_req = s.reset_req;
    assign wake_req = s.wake_req;
    assign timeout_flag = s.timeout_flag;
    assign powerdown_flag = s.pd_flag;
    assign watchdog_active = s.active;

endmodule
`default_nettype wire

// ### rtl/wdt_lf_tick.sv
// Purpose: divides hclk down to the low-frequency watchdog tick
// Assumes: run and restart come from logic on hclk
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defs.svh"
module wdt_lf_tick #(
    parameter int DIV = `WDT_LF_DIV
) (
    input wire logic hclk,
    input wire logic hresetn,
    wdt_tick_if.gen tk
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } div_state_s;

    div_state_s s;
    div_state_s n;

    always_comb begin
        n = s;
        n.tick = 1'b0;
        if (!tk.run || tk.restart) begin
            n.cnt = '0;
        end else if (s.cnt == LAST) begin
            n.cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + CW'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tk.tick = s.tick;
endmodule
`default_nettype wire
